/* File: sgp_pkg.sv */
// Purpose: constants and carrier types for the switch gpio port
// Assumes: 25 MHz core clock, eleven pins
// Notes:   register select codes address the upstream config space window
package sgp_pkg;

   localparam int NUM_PINS        = 11;
   localparam int CLK_PERIOD_NS   = 40;
   localparam int SAMPLE_MIN_NS   = 128;
   // least interval, so round up to whole cycles
   localparam int SAMPLE_CYCLES   =
      (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CNT_W    = $clog2(SAMPLE_CYCLES);

   localparam logic [1:0] REG_FUNC_SEL = 2'h0;
   localparam logic [1:0] REG_DIR      = 2'h1;
   localparam logic [1:0] REG_DATA     = 2'h2;

   localparam logic [10:0] FUNC_RESET  = 11'h000;
   localparam logic [10:0] DIR_RESET   = 11'h000;
   localparam logic [10:0] DATA_RESET  = 11'h000;

   // pins whose alternate function drives the pin
   localparam logic [10:0] ALT_OUT_MASK = 11'h783;

   localparam int PIN_DS2_RST  = 0;
   localparam int PIN_DS4_RST  = 1;
   localparam int PIN_IRQ0     = 2;
   localparam int PIN_EVENT    = 7;
   localparam int PIN_DS1_RST  = 8;
   localparam int PIN_DS3_RST  = 9;
   localparam int PIN_DS5_RST  = 10;
   localparam int NUM_IRQ      = 4;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  sel;
      logic [10:0] wdata;
   } sgp_cfg_req_t;

   typedef struct packed {
      logic downstream1_reset_out_n;
      logic downstream2_reset_out_n;
      logic downstream3_reset_out_n;
      logic downstream4_reset_out_n;
      logic downstream5_reset_out_n;
      logic event_out_n;
   } sgp_alt_drive_t;

endpackage

/* File: sgp_port.sv */
// Purpose: eleven-pin general purpose port with shared alternate functions
// Assumes: pins arrive unsynchronised; config access is one request a cycle
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/10ps

module sgp_port
#(
   parameter int PINS = sgp_pkg::NUM_PINS
)
(
   input  wire logic                    core_clk,
   input  wire logic                    rstn,
   input  wire sgp_pkg::sgp_cfg_req_t   cfg_req,
   output logic [PINS-1:0]              cfg_rdata,
   output logic                         cfg_rvalid,
   input  wire sgp_pkg::sgp_alt_drive_t alt_drive,
   output logic [sgp_pkg::NUM_IRQ-1:0]  expander_irq_n,
   input  wire logic [PINS-1:0]         pin_in,
   output logic [PINS-1:0]              pin_out,
   output logic [PINS-1:0]              pin_oe
);

   // the pin map is fixed by the package, so no other width can be served
   if (PINS != sgp_pkg::NUM_PINS)
   begin : g_bad_pins
      $error("sgp_port: PINS must equal the fixed pin count");
   end

   localparam int CW = (sgp_pkg::SAMPLE_CNT_W < 1) ? 1
                                                   : sgp_pkg::SAMPLE_CNT_W;
   localparam logic [CW-1:0] SAMPLE_LAST =
      CW'(sgp_pkg::SAMPLE_CYCLES - 1);

   logic [PINS-1:0] func_reg;
   logic [PINS-1:0] dir_reg;
   logic [PINS-1:0] out_val_reg;
   logic [PINS-1:0] sync1_reg;
   logic [PINS-1:0] sync2_reg;
   logic [PINS-1:0] level_reg;
   logic [CW-1:0]   samp_cnt_reg;
   logic [PINS-1:0] rdata_reg;
   logic            rvalid_reg;
   logic [PINS-1:0] pin_out_reg;
   logic [PINS-1:0] pin_oe_reg;
   logic [sgp_pkg::NUM_IRQ-1:0] irq_reg;

   logic [PINS-1:0] func_next;
   logic [PINS-1:0] dir_next;
   logic [PINS-1:0] out_val_next;
   logic [PINS-1:0] level_next;
   logic [CW-1:0]   samp_cnt_next;
   logic [PINS-1:0] rdata_next;
   logic [PINS-1:0] pin_out_next;
   logic [PINS-1:0] pin_oe_next;
   logic [sgp_pkg::NUM_IRQ-1:0] irq_next;

   wire             wr_func;
   wire             wr_dir;
   wire             wr_data;
   wire             samp_tick;
   wire [PINS-1:0]  alt_val;
   wire [PINS-1:0]  irq_field;

   // register decode in the upstream port config space
   assign wr_func  = cfg_req.wr && (cfg_req.sel == sgp_pkg::REG_FUNC_SEL);
   assign wr_dir   = cfg_req.wr && (cfg_req.sel == sgp_pkg::REG_DIR);
   assign wr_data  = cfg_req.wr && (cfg_req.sel == sgp_pkg::REG_DATA);

   assign func_next    = wr_func ? cfg_req.wdata : func_reg;
   assign dir_next     = wr_dir  ? cfg_req.wdata : dir_reg;
   // stored for every pin; only output-mode pins put it on the wire
   assign out_val_next = wr_data ? cfg_req.wdata : out_val_reg;

   assign rdata_next =
      (cfg_req.sel == sgp_pkg::REG_FUNC_SEL) ? func_reg  :
      (cfg_req.sel == sgp_pkg::REG_DIR)      ? dir_reg   :
      (cfg_req.sel == sgp_pkg::REG_DATA)     ? level_reg :
                                               '0;

   // sample clock: one capture every SAMPLE_CYCLES edges keeps the
   // interval at or above the minimum
   assign samp_tick     = (samp_cnt_reg == SAMPLE_LAST);
   assign samp_cnt_next = samp_tick ? '0 : samp_cnt_reg + CW'(1);
   // all pins are captured so a read shows the true level in any mode
   assign level_next    = samp_tick ? sync2_reg : level_reg;

   // alternate outputs gathered into pin order; non-driving pins idle high
   assign alt_val = {
      alt_drive.downstream5_reset_out_n,     // pin 10
      alt_drive.downstream3_reset_out_n,     // pin 9
      alt_drive.downstream1_reset_out_n,     // pin 8
      alt_drive.event_out_n,                 // pin 7
      1'b1,                                  // pin 6 has no alternate
      4'hf,                                  // pins 2..5 are inputs
      alt_drive.downstream4_reset_out_n,     // pin 1
      alt_drive.downstream2_reset_out_n      // pin 0
   };

   // func 1 selects alternate regardless of direction
   assign pin_oe_next  = (func_reg & sgp_pkg::ALT_OUT_MASK)
                       | (~func_reg & dir_reg);
   assign pin_out_next = (func_reg & alt_val)
                       | (~func_reg & out_val_reg);

   // interrupts come from the sampled level; forced inactive (high)
   // while the pin serves general purpose use
   assign irq_field = level_reg | ~func_reg;
   assign irq_next  =
      irq_field[sgp_pkg::PIN_IRQ0 +: sgp_pkg::NUM_IRQ];

   // synchroniser: sync1 feeds only sync2
   always_ff @(posedge core_clk)
   begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         func_reg     <= sgp_pkg::FUNC_RESET;
         dir_reg      <= sgp_pkg::DIR_RESET;
         out_val_reg  <= sgp_pkg::DATA_RESET;
         level_reg    <= '0;
         samp_cnt_reg <= '0;
      end
      else
      begin
         func_reg     <= func_next;
         dir_reg      <= dir_next;
         out_val_reg  <= out_val_next;
         level_reg    <= level_next;
         samp_cnt_reg <= samp_cnt_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         rdata_reg   <= '0;
         rvalid_reg  <= 1'b0;
         pin_out_reg <= '0;
         pin_oe_reg  <= '0;
         irq_reg     <= '1;
      end
      else
      begin
         rdata_reg   <= cfg_req.rd ? rdata_next : '0;
         rvalid_reg  <= cfg_req.rd;
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
         irq_reg     <= irq_next;
      end
   end

   assign cfg_rdata      = rdata_reg;
   assign cfg_rvalid     = rvalid_reg;
   assign pin_out        = pin_out_reg;
   assign pin_oe         = pin_oe_reg;
   assign expander_irq_n = irq_reg;

endmodule

/* File: sgp_board.sv */
// Purpose: board wiring seen by the gpio pins
// Assumes: the board level holds wherever the port does not drive
// Notes:   outputs are taken as plain levels with no clock relation
`timescale 1ns/10ps
module sgp_board
(
   input  wire logic [10:0] pin_out,
   input  wire logic [10:0] pin_oe,
   input  wire logic [10:0] ext_level,
   output logic      [10:0] pin_in
);
   // board drives only undriven pins, so no contention
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: sgp_port_chk.sv */
// Purpose: port checker for the switch gpio port
// Assumes: pins stay steady while configuration writes land
// Notes:   bound to every sgp_port instance
`timescale 1ns/10ps
module sgp_chk
#(
   parameter int PINS = sgp_pkg::NUM_PINS
)
(
   input wire logic                    core_clk,
   input wire logic                    rstn,
   input wire sgp_pkg::sgp_cfg_req_t   cfg_req,
   input wire logic [PINS-1:0]         cfg_rdata,
   input wire logic                    cfg_rvalid,
   input wire sgp_pkg::sgp_alt_drive_t alt_drive,
   input wire logic [sgp_pkg::NUM_IRQ-1:0] expander_irq_n,
   input wire logic [PINS-1:0]         pin_in,
   input wire logic [PINS-1:0]         pin_out,
   input wire logic [PINS-1:0]         pin_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_RD_ANSWER: assert property (cfg_req.rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_RD_QUIET: assert property (!cfg_req.rd |=> !cfg_rvalid && cfg_rdata == '0)
      else $error("read data outside a read");
   AST_UNMAPPED: assert property (cfg_req.rd && cfg_req.sel == 2'h3 |=> cfg_rdata == '0)
      else $error("unmapped read not zero");
   AST_RESET_STATE: assert property ($rose(rstn) |-> pin_oe == '0 && expander_irq_n == 4'hf)
      else $error("pins not idle after reset");
   AST_ALT_DRIVE: assert property ((cfg_req.wr && cfg_req.sel == 2'h0 && cfg_req.wdata == 11'h7ff ##1 !cfg_req.wr) |=> pin_oe == sgp_pkg::ALT_OUT_MASK)
      else $error("alternate drive set wrong");
   AST_IRQ_SRC: assert property ((cfg_req.wr && cfg_req.sel == 2'h0 && !cfg_req.wdata[2]) |=> ##1 expander_irq_n[0])
      else $error("interrupt not held inactive in general purpose use");
   AST_SAMPLE_GAP: assert property (!cfg_req.wr ##1 !cfg_req.wr ##1 (!cfg_req.wr && $changed(expander_irq_n)) |=> $stable(expander_irq_n)[*2])
      else $error("pins sampled too often");
   AST_OE_CAUSE: assert property ($changed(pin_oe) |-> $past(cfg_req.wr, 2))
      else $error("drive changed without a write");
endmodule
bind sgp_port sgp_chk #(.PINS(PINS)) u_chk (.core_clk(core_clk), .rstn(rstn),
   .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
   .alt_drive(alt_drive), .expander_irq_n(expander_irq_n), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe));

/* File: testbench.sv */
// Purpose: random configuration test of the switch gpio port
// Assumes: the data register reads back the sampled pin level
// Notes:   pins settle ten cycles before each configuration's pin comparisons
`timescale 1ns/10ps
module testbench;
   logic                    core_clk = 1'b0;
   logic                    rstn = 1'b0;
   sgp_pkg::sgp_cfg_req_t   cfg_req = '0;
   sgp_pkg::sgp_alt_drive_t alt_drive = '1;
   logic [10:0]             ext_level = 11'h000;
   logic [10:0]             pin_in, pin_out, pin_oe, cfg_rdata, rdata;
   logic [10:0]             fn, dr, dt, av, eoe, eout, lvl;
   logic [3:0]              expander_irq_n;
   logic                    cfg_rvalid;
   logic [31:0]             seed = 32'he323;
   int                      bad_count = 0;
   int                      checked = 0;
   sgp_port #(.PINS(11)) dut (.core_clk(core_clk), .rstn(rstn),
      .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .alt_drive(alt_drive), .expander_irq_n(expander_irq_n),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   sgp_board board (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));
   always #20 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // idle cycle before each request so strobes never toggle twice a step
   task automatic bus(input logic w, input logic [1:0] s, input logic [10:0] d);
      @(posedge core_clk);
      #1 cfg_req = {w, ~w, s, d};
      @(posedge core_clk);
      #1 cfg_req = '0;
      rdata = cfg_rdata;
      if (!w)
         check("cfg_rvalid", {10'h000, cfg_rvalid}, 11'h001);
   endtask
   task automatic check(input string n, input logic [10:0] s, input logic [10:0] e);
      checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #(40 * 5000);
      bad_count++;
      give_verdict;
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      #1 rstn = 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b0, 2'(s), 11'h000);
         check("reset read", rdata, 11'h000);
      end
      $display("test reset done");
      for (int k = 0; k < 24; k++)
      begin
         fn = (k == 0) ? 11'h7ff : 11'(rnd());
         dr = 11'(rnd());
         dt = 11'(rnd());
         bus(1'b1, 2'h0, fn);
         bus(1'b1, 2'h1, dr);
         bus(1'b1, 2'h2, dt);
         ext_level = 11'(rnd());
         alt_drive = 6'(rnd());
         repeat (10) @(posedge core_clk);
         #1 eoe = (fn & sgp_pkg::ALT_OUT_MASK) | (~fn & dr);
         av = {alt_drive.downstream5_reset_out_n, alt_drive.downstream3_reset_out_n,
            alt_drive.downstream1_reset_out_n, alt_drive.event_out_n, 5'h00,
            alt_drive.downstream4_reset_out_n, alt_drive.downstream2_reset_out_n};
         eout = (fn & av) | (~fn & dt);
         lvl = (eoe & eout) | (~eoe & ext_level);
         check("pin_oe", pin_oe, eoe);
         check("pin_out", pin_out & eoe, eout & eoe);
         check("expander_irq_n", {7'h0, expander_irq_n}, {7'h0, ~fn[5:2] | lvl[5:2]});
         bus(1'b0, 2'h2, 11'h000);
         check("pin_data", rdata, lvl);
         bus(1'b0, 2'h0, 11'h000);
         check("pin_function_select", rdata, fn);
         bus(1'b0, 2'h1, 11'h000);
         check("pin_direction", rdata, dr);
         $display("test config %0d done", k);
      end
      give_verdict;
   end
endmodule
